// [prot_defines.svh]
`ifndef PROT_DEFINES_SVH
`define PROT_DEFINES_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFS_BLOCK_WRITE_LOCK 22'h30000a
`define OFS_SPECIAL_WRITE_LOCK 22'h30000b
`define OFS_BLOCK_TABLE_READ_LOCK 22'h30000c
`define OFS_BOOT_TABLE_READ_LOCK 22'h30000d
`define OFS_IDENT_LOW 22'h3ffffe
`define OFS_IDENT_HIGH 22'h3fffff
// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define BWL_MASK 8'h0f
`define SWL_MASK 8'he0
`define BTRL_MASK 8'h0f
`define BOOT_TRL_MASK 8'h40
`define BIT_EEPROM_LOCK 7
`define BIT_BOOT_LOCK 6
`define BIT_CONFIG_LOCK 5
`define BIT_BOOT_FENCE 6
`define UNPROG_VALUE 8'hff
`define ZERO_BYTE 8'h00
`endif

// [prot_pkg.sv]
`default_nettype none
package prot_pkg;
  // Access request toward program memory
  typedef struct packed {
    logic valid;
    logic is_write;
    logic [21:0] addr;
    logic [21:0] exec_addr;
  } mem_req_s;
  // Region of an address
  typedef enum logic [2:0] {
    REG_BOOT,
    REG_B0,
    REG_B1,
    REG_B2,
    REG_B3,
    REG_NONE
  } region_e;
  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [21:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
endpackage : prot_pkg
`default_nettype wire

// [region_map.sv]
`default_nettype none
module region_map #(
  parameter logic [21:0] BOOT_END = 22'h0001ff,
  parameter logic [21:0] B0_END = 22'h000fff,
  parameter logic [21:0] B1_END = 22'h001fff,
  parameter logic [21:0] B2_END = 22'h002fff,
  parameter logic [21:0] B3_END = 22'h003fff
) (
  // Address in, region out
  input wire logic [21:0] addr,
  output var prot_pkg::region_e region
);
  // Overlapping ranges would let one address pick up the wrong lock bits
  if (!(BOOT_END < B0_END && B0_END < B1_END && B1_END < B2_END && B2_END < B3_END)) begin : g_bad_ends
    $error("region ends must ascend");
  end
  always_comb begin
    if (addr <= BOOT_END) begin
      region = prot_pkg::REG_BOOT;
    end else if (addr <= B0_END) begin
      region = prot_pkg::REG_B0;
    end else if (addr <= B1_END) begin
      region = prot_pkg::REG_B1;
    end else if (addr <= B2_END) begin
      region = prot_pkg::REG_B2;
    end else if (addr <= B3_END) begin
      region = prot_pkg::REG_B3;
    end else begin
      region = prot_pkg::REG_NONE;
    end
  end
endmodule : region_map
`default_nettype wire

// [block_protect.sv]
// Decided for this implementation: the plain strobed port.
`include "prot_defines.svh"
`default_nettype none
module block_protect #(
  parameter logic [21:0] BOOT_END = 22'h0001ff,
  parameter logic [21:0] B0_END = 22'h000fff,
  parameter logic [21:0] B1_END = 22'h001fff,
  parameter logic [21:0] B2_END = 22'h002fff,
  parameter logic [21:0] B3_END = 22'h003fff,
  parameter int NUM_BLOCKS = 4,
  // Arbitrary identity values
  parameter logic [2:0] PART_IDENT_LOW = 3'h6,
  parameter logic [7:0] PART_IDENT_HIGH = 8'h5a,
  parameter logic [4:0] SILICON_REVISION = 5'h01
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Mode
  input wire logic prog_mode,
  // Register port
  input wire prot_pkg::reg_req_s reg_req,
  output logic [7:0] rdata,
  // Program memory access check
  input wire prot_pkg::mem_req_s mem_req,
  output logic mem_grant,
  output logic mem_deny,
  // Data EEPROM write check
  input wire logic ee_wr_req,
  output logic ee_wr_grant,
  output logic ee_wr_deny,
  // Live lock state
  output logic config_write_lock
);
  // Lock decode below serves exactly four blocks
  if (NUM_BLOCKS != 4) begin : g_bad_blocks
    $error("NUM_BLOCKS must be 4");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] bwl;
    logic [7:0] swl;
    logic [7:0] btrl;
    logic [7:0] boot_trl;
    logic [7:0] rdata;
    logic mem_grant;
    logic mem_deny;
    logic ee_grant;
    logic ee_deny;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  prot_pkg::region_e tgt_region;
  prot_pkg::region_e exec_region;

  region_map #(
    .BOOT_END(BOOT_END),
    .B0_END(B0_END),
    .B1_END(B1_END),
    .B2_END(B2_END),
    .B3_END(B3_END)
  ) u_map_tgt (
    .addr(mem_req.addr),
    .region(tgt_region)
  );

  region_map #(
    .BOOT_END(BOOT_END),
    .B0_END(B0_END),
    .B1_END(B1_END),
    .B2_END(B2_END),
    .B3_END(B3_END)
  ) u_map_exec (
    .addr(mem_req.exec_addr),
    .region(exec_region)
  );

  // ----------------------------------------
  // Lock decode for the addressed region
  // ----------------------------------------
  logic wlock_n;
  logic fence_n;
  logic cfg_target;

  always_comb begin
    wlock_n = 1'b1;
    fence_n = 1'b1;
    case (tgt_region)
      prot_pkg::REG_BOOT: begin
        wlock_n = st_ff.swl[`BIT_BOOT_LOCK];
        fence_n = st_ff.boot_trl[`BIT_BOOT_FENCE];
      end
      prot_pkg::REG_B0: begin
        wlock_n = st_ff.bwl[0];
        fence_n = st_ff.btrl[0];
      end
      prot_pkg::REG_B1: begin
        wlock_n = st_ff.bwl[1];
        fence_n = st_ff.btrl[1];
      end
      prot_pkg::REG_B2: begin
        wlock_n = st_ff.bwl[2];
        fence_n = st_ff.btrl[2];
      end
      prot_pkg::REG_B3: begin
        wlock_n = st_ff.bwl[3];
        fence_n = st_ff.btrl[3];
      end
      default: begin
        wlock_n = 1'b1;
        fence_n = 1'b1;
      end
    endcase
  end

  assign cfg_target = (reg_req.addr == `OFS_BLOCK_WRITE_LOCK) ||
                      (reg_req.addr == `OFS_SPECIAL_WRITE_LOCK) ||
                      (reg_req.addr == `OFS_BLOCK_TABLE_READ_LOCK) ||
                      (reg_req.addr == `OFS_BOOT_TABLE_READ_LOCK);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic cfg_ok;
  logic mem_ok;

  always_comb begin
    nxt_st = st_ff;
    cfg_ok = reg_req.wr && cfg_target &&
             (st_ff.swl[`BIT_CONFIG_LOCK] || prog_mode);
    if (cfg_ok) begin
      if (reg_req.addr == `OFS_BLOCK_WRITE_LOCK) begin
        nxt_st.bwl = reg_req.wdata & `BWL_MASK;
      end else if (reg_req.addr == `OFS_SPECIAL_WRITE_LOCK) begin
        nxt_st.swl[`BIT_EEPROM_LOCK] = reg_req.wdata[`BIT_EEPROM_LOCK];
        nxt_st.swl[`BIT_BOOT_LOCK] = reg_req.wdata[`BIT_BOOT_LOCK];
        if (prog_mode) begin
          nxt_st.swl[`BIT_CONFIG_LOCK] = reg_req.wdata[`BIT_CONFIG_LOCK];
        end
      end else if (reg_req.addr == `OFS_BLOCK_TABLE_READ_LOCK) begin
        nxt_st.btrl = reg_req.wdata & `BTRL_MASK;
      end else begin
        nxt_st.boot_trl = reg_req.wdata & `BOOT_TRL_MASK;
      end
    end

    // Register read data, one cycle after the strobe
    nxt_st.rdata = `ZERO_BYTE;
    if (reg_req.rd) begin
      if (reg_req.addr == `OFS_BLOCK_WRITE_LOCK) begin
        nxt_st.rdata = st_ff.bwl;
      end else if (reg_req.addr == `OFS_SPECIAL_WRITE_LOCK) begin
        nxt_st.rdata = st_ff.swl;
      end else if (reg_req.addr == `OFS_BLOCK_TABLE_READ_LOCK) begin
        nxt_st.rdata = st_ff.btrl;
      end else if (reg_req.addr == `OFS_BOOT_TABLE_READ_LOCK) begin
        nxt_st.rdata = st_ff.boot_trl;
      end else if (reg_req.addr == `OFS_IDENT_LOW) begin
        nxt_st.rdata = {PART_IDENT_LOW, SILICON_REVISION};
      end else if (reg_req.addr == `OFS_IDENT_HIGH) begin
        nxt_st.rdata = PART_IDENT_HIGH;
      end else begin
        nxt_st.rdata = `ZERO_BYTE;
      end
    end

    // Program memory check: verdict one cycle after a valid request
    mem_ok = 1'b1;
    if (mem_req.is_write) begin
      mem_ok = wlock_n;
    end else if (tgt_region != exec_region) begin
      mem_ok = fence_n;
    end
    nxt_st.mem_grant = mem_req.valid && mem_ok;
    nxt_st.mem_deny = mem_req.valid && !mem_ok;

    nxt_st.ee_grant = ee_wr_req && st_ff.swl[`BIT_EEPROM_LOCK];
    nxt_st.ee_deny = ee_wr_req && !st_ff.swl[`BIT_EEPROM_LOCK];
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // lock registers reset to unprogrammed value under their masks; rdata, grants and denies reset to zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '{bwl: `UNPROG_VALUE & `BWL_MASK,
                 swl: `UNPROG_VALUE & `SWL_MASK,
                 btrl: `UNPROG_VALUE & `BTRL_MASK,
                 boot_trl: `UNPROG_VALUE & `BOOT_TRL_MASK,
                 rdata: `ZERO_BYTE,
                 mem_grant: 1'b0,
                 mem_deny: 1'b0,
                 ee_grant: 1'b0,
                 ee_deny: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = st_ff.rdata;
  assign mem_grant = st_ff.mem_grant;
  assign mem_deny = st_ff.mem_deny;
  assign ee_wr_grant = st_ff.ee_grant;
  assign ee_wr_deny = st_ff.ee_deny;
  assign config_write_lock = st_ff.swl[`BIT_CONFIG_LOCK];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_ee_deny;
    @(posedge clk) disable iff (!resetn)
      (ee_wr_req && !st_ff.swl[`BIT_EEPROM_LOCK]) |=> (ee_wr_deny && !ee_wr_grant);
  endproperty
  a_ee_deny: assert property (p_ee_deny) else $error("eeprom write not refused");

  property p_ee_grant;
    @(posedge clk) disable iff (!resetn)
      (ee_wr_req && st_ff.swl[`BIT_EEPROM_LOCK]) |=> ee_wr_grant;
  endproperty
  a_ee_grant: assert property (p_ee_grant) else $error("eeprom write not granted");

  property p_blk_write;
    @(posedge clk) disable iff (!resetn)
      (mem_req.valid && mem_req.is_write && tgt_region == prot_pkg::REG_B0 && !st_ff.bwl[0])
      |=> mem_deny;
  endproperty
  a_blk_write: assert property (p_blk_write) else $error("locked block write passed");

  property p_boot_write;
    @(posedge clk) disable iff (!resetn)
      (mem_req.valid && mem_req.is_write && tgt_region == prot_pkg::REG_BOOT &&
       !st_ff.swl[`BIT_BOOT_LOCK]) |=> mem_deny;
  endproperty
  a_boot_write: assert property (p_boot_write) else $error("locked boot write passed");

  property p_cfg_lock;
    @(posedge clk) disable iff (!resetn)
      (!st_ff.swl[`BIT_CONFIG_LOCK] && !prog_mode) |=> $stable(st_ff.bwl);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock) else $error("locked config changed");

  property p_cfg_bit_ro;
    @(posedge clk) disable iff (!resetn)
      !prog_mode |=> $stable(config_write_lock);
  endproperty
  a_cfg_bit_ro: assert property (p_cfg_bit_ro) else $error("config lock changed");

  property p_fence;
    @(posedge clk) disable iff (!resetn)
      (mem_req.valid && !mem_req.is_write && tgt_region == prot_pkg::REG_B1 &&
       exec_region != prot_pkg::REG_B1 && !st_ff.btrl[1]) |=> mem_deny;
  endproperty
  a_fence: assert property (p_fence) else $error("fenced table read passed");

  property p_boot_fence;
    @(posedge clk) disable iff (!resetn)
      (mem_req.valid && !mem_req.is_write && tgt_region == prot_pkg::REG_BOOT &&
       exec_region != prot_pkg::REG_BOOT && !st_ff.boot_trl[`BIT_BOOT_FENCE]) |=> mem_deny;
  endproperty
  a_boot_fence: assert property (p_boot_fence) else $error("boot fence read passed");

  property p_reserved_zero;
    @(posedge clk) disable iff (!resetn)
      (st_ff.bwl & ~`BWL_MASK) == `ZERO_BYTE && (st_ff.btrl & ~`BTRL_MASK) == `ZERO_BYTE;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_ident;
    @(posedge clk) disable iff (!resetn)
      (reg_req.rd && reg_req.addr == `OFS_IDENT_LOW) |=>
        rdata == {PART_IDENT_LOW, SILICON_REVISION};
  endproperty
  a_ident: assert property (p_ident) else $error("ident low wrong");

  property p_ident_hi;
    @(posedge clk) disable iff (!resetn)
      (reg_req.rd && reg_req.addr == `OFS_IDENT_HIGH) |=> rdata == PART_IDENT_HIGH;
  endproperty
  a_ident_hi: assert property (p_ident_hi) else $error("ident high wrong");
endmodule : block_protect
`default_nettype wire

// [tb.sv]
`include "prot_defines.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Identity values (arbitrary)
  // ----------------------------------------
  localparam logic [2:0] ID_LO = 3'h3;
  localparam logic [7:0] ID_HI = 8'ha7;
  localparam logic [4:0] REV = 5'h0b;
  localparam logic [21:0] BOOT = 22'h000100;

  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic prog_mode = 1'b0;
  logic ee_wr_req = 1'b0;
  prot_pkg::reg_req_s reg_req = '0;
  prot_pkg::mem_req_s mem_req = '0;
  logic [7:0] rdata;
  logic mem_grant, mem_deny, ee_wr_grant, ee_wr_deny, config_write_lock;
  int error_cnt = 0;
  int n_tests = 0;
  logic [7:0] exp_q[$];
  logic pend_rd = 1'b0;
  logic pend_mem = 1'b0;
  logic pend_ee = 1'b0;
  logic [7:0] v;

`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end

  always #25 clk = ~clk;

  block_protect #(
    .PART_IDENT_LOW(ID_LO),
    .PART_IDENT_HIGH(ID_HI),
    .SILICON_REVISION(REV)
  ) block_protect_i (
    .clk(clk),
    .resetn(resetn),
    .prog_mode(prog_mode),
    .reg_req(reg_req),
    .rdata(rdata),
    .mem_req(mem_req),
    .mem_grant(mem_grant),
    .mem_deny(mem_deny),
    .ee_wr_req(ee_wr_req),
    .ee_wr_grant(ee_wr_grant),
    .ee_wr_deny(ee_wr_deny),
    .config_write_lock(config_write_lock)
  );

  // ----------------------------------------
  // Result watcher
  // ----------------------------------------
  task automatic pop_cmp(input logic [7:0] got);
    logic [7:0] e;
    e = (exp_q.size() == 0) ? 8'hxx : exp_q.pop_front();
    `CHK(got, e)
  endtask : pop_cmp

  // Stray grant or deny pulses find an empty queue and count as errors
  always @(negedge clk) begin
    if (pend_rd) pop_cmp(rdata);
    if (pend_mem || mem_grant || mem_deny) pop_cmp({6'h00, mem_grant, mem_deny});
    if (pend_ee || ee_wr_grant || ee_wr_deny) pop_cmp({6'h00, ee_wr_grant, ee_wr_deny});
    pend_rd = reg_req.rd;
    pend_mem = mem_req.valid;
    pend_ee = ee_wr_req;
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic wr(input logic [21:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    reg_req <= '0;
  endtask : wr

  task automatic rd(input logic [21:0] a, input logic [7:0] e);
    @(posedge clk);
    exp_q.push_back(e);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    reg_req <= '0;
  endtask : rd

  task automatic mem(input logic w, input logic [21:0] a, input logic [21:0] x,
                     input logic g);
    @(posedge clk);
    exp_q.push_back({6'h00, g, ~g});
    mem_req <= '{valid: 1'b1, is_write: w, addr: a, exec_addr: x};
    @(posedge clk);
    mem_req <= '0;
  endtask : mem

  task automatic ee(input logic g);
    @(posedge clk);
    exp_q.push_back({6'h00, g, ~g});
    ee_wr_req <= 1'b1;
    @(posedge clk);
    ee_wr_req <= 1'b0;
  endtask : ee

  function automatic logic [21:0] blk(input int i);
    return 22'h000800 + 22'(i) * 22'h001000;
  endfunction : blk

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(90612));
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    rd(`OFS_BLOCK_WRITE_LOCK, 8'h0f);
    rd(`OFS_SPECIAL_WRITE_LOCK, 8'he0);
    rd(`OFS_BLOCK_TABLE_READ_LOCK, 8'h0f);
    rd(`OFS_BOOT_TABLE_READ_LOCK, 8'h40);
    rd(`OFS_IDENT_LOW, {ID_LO, REV});
    rd(`OFS_IDENT_HIGH, ID_HI);
    rd(22'h30000e, 8'h00);
    wr(`OFS_IDENT_LOW, 8'h00);
    rd(`OFS_IDENT_LOW, {ID_LO, REV});
    // Second pass inverts every lock bit so each block sees both states
    for (int k = 0; k < 2; k++) begin
      v = (k == 0) ? 8'($urandom) : ~v;
      wr(`OFS_BLOCK_WRITE_LOCK, v);
      rd(`OFS_BLOCK_WRITE_LOCK, v & 8'h0f);
      wr(`OFS_BLOCK_TABLE_READ_LOCK, v);
      rd(`OFS_BLOCK_TABLE_READ_LOCK, v & 8'h0f);
      for (int i = 0; i < 4; i++) begin
        mem(1'b1, blk(i), blk((i + 1) % 4), v[i]);
        mem(1'b0, blk(i), blk((i + 1) % 4), v[i]);
        mem(1'b0, blk(i) + 22'h000010, blk(i), 1'b1);
      end
    end
    wr(`OFS_BOOT_TABLE_READ_LOCK, 8'h00);
    rd(`OFS_BOOT_TABLE_READ_LOCK, 8'h00);
    mem(1'b0, BOOT, blk(0), 1'b0);
    mem(1'b0, BOOT, BOOT + 22'h000004, 1'b1);
    mem(1'b0, 22'h0001ff, 22'h000200, 1'b0);
    mem(1'b0, 22'h000200, 22'h0001ff, v[0]);
    wr(`OFS_BOOT_TABLE_READ_LOCK, 8'hff);
    rd(`OFS_BOOT_TABLE_READ_LOCK, 8'h40);
    mem(1'b0, BOOT, blk(2), 1'b1);
    wr(`OFS_SPECIAL_WRITE_LOCK, 8'h00);
    rd(`OFS_SPECIAL_WRITE_LOCK, 8'h20);
    ee(1'b0);
    mem(1'b1, BOOT, blk(0), 1'b0);
    wr(`OFS_SPECIAL_WRITE_LOCK, 8'hc0);
    rd(`OFS_SPECIAL_WRITE_LOCK, 8'he0);
    ee(1'b1);
    mem(1'b1, BOOT, blk(0), 1'b1);
    prog_mode <= 1'b1;
    wr(`OFS_SPECIAL_WRITE_LOCK, 8'h40);
    rd(`OFS_SPECIAL_WRITE_LOCK, 8'h40);
    @(negedge clk);
    `CHK({7'h00, config_write_lock}, 8'h00)
    @(posedge clk);
    prog_mode <= 1'b0;
    wr(`OFS_BLOCK_WRITE_LOCK, ~v);
    rd(`OFS_BLOCK_WRITE_LOCK, v & 8'h0f);
    wr(`OFS_SPECIAL_WRITE_LOCK, 8'he0);
    rd(`OFS_SPECIAL_WRITE_LOCK, 8'h40);
    prog_mode <= 1'b1;
    wr(`OFS_SPECIAL_WRITE_LOCK, 8'he0);
    rd(`OFS_SPECIAL_WRITE_LOCK, 8'he0);
    // Reset in mid-run must bring back the unprogrammed values
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(`OFS_BLOCK_WRITE_LOCK, 8'h0f);
    rd(`OFS_SPECIAL_WRITE_LOCK, 8'he0);
    for (int t = 0; t < 8 && exp_q.size() != 0; t++) @(posedge clk);
    if (exp_q.size() != 0) error_cnt++;
    report_and_stop();
  end

`undef CHK
endmodule : tb
`default_nettype wire
